/* File: design/efr_sync_event_reporting.sv */
`timescale 1ns/1ps
`default_nettype none
`include "efr_map.svh"

module efr_sync_event_reporting
    import efr_pkg::*;
#(
    parameter int WINDOW_CYCLES = `EFR_WINDOW_NS / `EFR_CLK_NS
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [10:0]      avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    output logic                  irq,
    input  wire logic [7:0]       interworking_state,
    input  wire logic [7:0]       sig_mf_out_of_sync,
    input  wire logic [7:0]       crc_mf_out_of_sync,
    input  wire logic [7:0]       offline_frame_out_of_sync,
    input  wire logic [7:0]       basic_frame_out_of_sync,
    input  wire logic [7:0]       sig_mf_start,
    input  wire logic [7:0]       crc_submf_start,
    input  wire logic [7:0]       crc_mf_start,
    input  wire logic [7:0]       sig_mfas_strobe,
    input  wire logic [7:0][3:0]  sig_mfas_word,
    input  wire logic [7:0]       crc_mfas_strobe,
    input  wire logic [7:0][5:0]  crc_mfas_bits,
    input  wire logic [7:0]       crc4_strobe,
    input  wire logic [7:0][3:0]  crc4_calc,
    input  wire logic [7:0][3:0]  crc4_rx,
    input  wire logic [7:0]       fas_strobe,
    input  wire logic [7:0][6:0]  fas_word,
    input  wire logic [7:0]       nfas_strobe,
    input  wire logic [7:0]       nfas_bit,
    input  wire logic [7:0]       align_found,
    input  wire logic [7:0][7:0]  align_pos
);

    efr_state_t q;
    efr_state_t next_q;

    // set wins over clear so an event in the clearing cycle survives
    function automatic logic [7:0] efr_w1c(input logic [7:0] old, input logic [7:0] set,
                                           input logic [7:0] clr);
        efr_w1c = (old & ~clr) | set;
    endfunction

    function automatic logic [7:0] efr_rd(input efr_state_t s, input logic [2:0] c,
                                          input logic [7:0] ofs);
        if (ofs == `EFR_OFS_STATE) begin
            efr_rd = {3'h0, s.live[c]};
        end else if (ofs == `EFR_OFS_SYNC_EN) begin
            efr_rd = s.sync_en[c];
        end else if (ofs == `EFR_OFS_EVT_EN) begin
            efr_rd = s.evt_en[c];
        end else if (ofs == `EFR_OFS_SYNC_FLG) begin
            efr_rd = s.sync_flg[c];
        end else if (ofs == `EFR_OFS_EVT_FLG) begin
            efr_rd = s.evt_flg[c];
        end else if (ofs == `EFR_OFS_ERR_CFG) begin
            efr_rd = s.cfg[c];
        end else begin
            efr_rd = 8'h00;
        end
    endfunction

    always_comb begin
        logic [2:0] ch;
        logic [7:0] ofs;
        logic       wr_now;
        logic       win_end;
        logic       crc_err;
        logic       fer;
        logic [4:0] live_in;
        logic [7:0] sset;
        logic [7:0] eset;
        logic [7:0] sclr;
        logic [7:0] eclr;
        logic       any;
        ch      = avs_address[`EFR_CH_MSB:`EFR_CH_LSB];
        ofs     = avs_address[7:0];
        wr_now  = 1'b0;
        win_end = (q.win == 28'(WINDOW_CYCLES - 1));
        crc_err = 1'b0;
        fer     = 1'b0;
        live_in = 5'h00;
        sset    = 8'h00;
        eset    = 8'h00;
        sclr    = 8'h00;
        eclr    = 8'h00;
        any     = 1'b0;
        next_q  = q;
        // fixed windows, shared by all channels
        next_q.win = win_end ? 28'h0 : q.win + 28'h1;
        case (q.bus)
            EFR_IDLE: begin
                if (avs_read || avs_write) begin
                    next_q.bus         = EFR_ACK;
                    next_q.waitrequest = 1'b0;
                    next_q.rdata       = {24'h0, efr_rd(q, ch, ofs)};
                end
            end
            EFR_ACK: begin
                next_q.bus         = EFR_IDLE;
                next_q.waitrequest = 1'b1;
                wr_now             = avs_write;
            end
            default: begin
                next_q.bus         = EFR_IDLE;
                next_q.waitrequest = 1'b1;
            end
        endcase
        for (int c = 0; c < 8; c++) begin
            sclr = 8'h00;
            eclr = 8'h00;
            if (wr_now && ch == 3'(c)) begin
                if (ofs == `EFR_OFS_SYNC_EN) begin
                    next_q.sync_en[c] = avs_writedata[7:0] & `EFR_SYNC_EN_MASK;
                end else if (ofs == `EFR_OFS_EVT_EN) begin
                    next_q.evt_en[c] = avs_writedata[7:0];
                end else if (ofs == `EFR_OFS_SYNC_FLG) begin
                    sclr = avs_writedata[7:0] & `EFR_SYNC_FLG_MASK;
                end else if (ofs == `EFR_OFS_EVT_FLG) begin
                    eclr = avs_writedata[7:0];
                end else if (ofs == `EFR_OFS_ERR_CFG) begin
                    next_q.cfg[c] = avs_writedata[7:0] & `EFR_CFG_MASK;
                end
            end
            live_in = {interworking_state[c], sig_mf_out_of_sync[c], crc_mf_out_of_sync[c],
                       offline_frame_out_of_sync[c], basic_frame_out_of_sync[c]};
            next_q.live[c] = live_in;
            sset = {3'h0, live_in ^ q.live[c]};
            crc_err = crc4_strobe[c] && (crc4_calc[c] != crc4_rx[c]);
            // counter saturates so a burst cannot wrap past the limit
            if (crc_mf_out_of_sync[c]) begin
                next_q.crc_cnt[c] = 10'h000;
            end else if (win_end) begin
                next_q.crc_cnt[c] = {9'h000, crc_err};
            end else if (crc_err && q.crc_cnt[c] != `EFR_CNT_MAX) begin
                next_q.crc_cnt[c] = q.crc_cnt[c] + 10'h001;
            end
            // fires once, on the error that takes the window to the limit
            sset[`EFR_B_EXCRC] = !crc_mf_out_of_sync[c] && !win_end && crc_err
                                 && (q.crc_cnt[c] == `EFR_EXCRC_LIMIT - 10'h001);
            eset = 8'h00;
            if (!sig_mf_out_of_sync[c]) begin
                eset[`EFR_B_SMFP]  = sig_mf_start[c];
                eset[`EFR_B_SMFER] = sig_mfas_strobe[c]
                                     && (sig_mfas_word[c] != `EFR_SMFAS_EXP);
            end
            if (!crc_mf_out_of_sync[c]) begin
                eset[`EFR_B_CSMFP] = crc_submf_start[c];
                eset[`EFR_B_CMFP]  = crc_mf_start[c];
                eset[`EFR_B_CMFER] = crc_mfas_strobe[c]
                                     && (crc_mfas_bits[c] != `EFR_CMFAS_EXP);
                eset[`EFR_B_CRCE]  = crc_err;
            end
            // nfas option adds the nfas bit check, pattern option bit has no effect; one flag either way
            fer = fas_strobe[c] && (fas_word[c] != `EFR_FAS_EXP);
            if (q.cfg[c][`EFR_CFG_NFAS_BIT]) begin
                fer = fer || (nfas_strobe[c] && (nfas_bit[c] != `EFR_NFAS_EXP));
            end
            eset[`EFR_B_FER] = !basic_frame_out_of_sync[c] && fer;
            if (align_found[c]) begin
                next_q.pos[c]    = align_pos[c];
                next_q.pos_ok[c] = 1'b1;
                eset[`EFR_B_COFA] = q.pos_ok[c] && (align_pos[c] != q.pos[c]);
            end
            next_q.sync_flg[c] = efr_w1c(q.sync_flg[c], sset, sclr);
            next_q.evt_flg[c]  = efr_w1c(q.evt_flg[c], eset, eclr);
            any = any || |(q.sync_flg[c] & q.sync_en[c]) || |(q.evt_flg[c] & q.evt_en[c]);
        end
        next_q.irq = any;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q             <= '0;
            q.bus         <= EFR_IDLE;
            q.waitrequest <= 1'b1;
            q.live        <= {8{`EFR_LIVE_RST}};
        end else begin
            q <= next_q;
        end
    end

    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = q.waitrequest;
    assign irq             = q.irq;

    iw_live_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        interworking_state[0] |=> q.live[0][4])
        else $error("interworking status not shown");
    sig_live_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !sig_mf_out_of_sync[0] |=> !q.live[0][3])
        else $error("signaling sync status wrong");
    crc_live_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        crc_mf_out_of_sync[0] |=> q.live[0][2])
        else $error("crc multiframe status wrong");
    ofl_live_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 q.live[0][1] == $past(offline_frame_out_of_sync[0]))
        else $error("offline frame status wrong");
    bf_live_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(basic_frame_out_of_sync[0]) |=> q.live[0][0] ##1 q.sync_flg[0][0])
        else $error("basic frame status or change flag wrong");
    change_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (interworking_state[0] != q.live[0][4]) |=> q.sync_flg[0][4])
        else $error("change flag missed");
    flag_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        q.evt_flg[0][7] && !(q.bus == EFR_ACK && avs_write) |=> q.evt_flg[0][7])
        else $error("flag dropped without clear");
    irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        |(q.evt_flg[0] & q.evt_en[0]) |=> irq)
        else $error("enabled flag did not raise irq");
    crc_mf_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        crc_mf_out_of_sync[0] && !q.evt_flg[0][4] |=> !q.evt_flg[0][4])
        else $error("crc multiframe flag set out of sync");
    set_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sig_mf_start[0] && !sig_mf_out_of_sync[0] |=> q.evt_flg[0][7])
        else $error("event lost against clear");

    // bus handshake: one wait cycle, then a single acknowledge cycle
    ack_follows_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest)
        else $error("request not acknowledged next cycle");
    ack_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("acknowledge stood longer than one cycle");
    rd_upper_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !avs_waitrequest |-> (avs_readdata[31:8] == 24'h000000))
        else $error("reserved read bits not zero");
    sig_mf_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sig_mf_out_of_sync[0] && !q.evt_flg[0][7] |=> !q.evt_flg[0][7])
        else $error("signaling multiframe flag set out of sync");
    submf_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        crc_mf_out_of_sync[0] && !q.evt_flg[0][6] |=> !q.evt_flg[0][6])
        else $error("sub-multiframe flag set out of sync");
    sig_align_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sig_mf_out_of_sync[0] && !q.evt_flg[0][5] |=> !q.evt_flg[0][5])
        else $error("signaling alignment error set out of sync");
    sig_align_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sig_mfas_strobe[0] && (sig_mfas_word[0] != `EFR_SMFAS_EXP) && !sig_mf_out_of_sync[0]
        |=> q.evt_flg[0][5])
        else $error("signaling alignment error missed");
    crc_align_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        crc_mf_out_of_sync[0] && !q.evt_flg[0][3] |=> !q.evt_flg[0][3])
        else $error("crc alignment error set out of sync");
    crc_align_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        crc_mfas_strobe[0] && (crc_mfas_bits[0] != `EFR_CMFAS_EXP) && !crc_mf_out_of_sync[0]
        |=> q.evt_flg[0][3])
        else $error("crc alignment error missed");
    crc4_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        crc_mf_out_of_sync[0] && !q.evt_flg[0][2] |=> !q.evt_flg[0][2])
        else $error("crc-4 error set out of sync");
    crc4_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        crc4_strobe[0] && (crc4_calc[0] != crc4_rx[0]) && !crc_mf_out_of_sync[0]
        |=> q.evt_flg[0][2])
        else $error("crc-4 error missed");
    fer_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        basic_frame_out_of_sync[0] && !q.evt_flg[0][1] |=> !q.evt_flg[0][1])
        else $error("framing error set out of sync");
    excess_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        crc_mf_out_of_sync[0] && !q.sync_flg[0][5] |=> !q.sync_flg[0][5])
        else $error("excessive crc-4 flag set out of sync");

endmodule // efr_sync_event_reporting
`default_nettype wire

/* File: include/efr_map.svh */
`ifndef EFR_MAP_SVH
`define EFR_MAP_SVH
`define EFR_OFS_ERR_CFG   8'h4E
`define EFR_OFS_STATE     8'h4F
`define EFR_OFS_SYNC_EN   8'h50
`define EFR_OFS_EVT_EN    8'h51
`define EFR_OFS_SYNC_FLG  8'h52
`define EFR_OFS_EVT_FLG   8'h53
`define EFR_CH_MSB        10
`define EFR_CH_LSB        8
`define EFR_SYNC_EN_MASK  8'h1F
`define EFR_SYNC_FLG_MASK 8'h3F
`define EFR_CFG_MASK      8'h18
`define EFR_CFG_NFAS_BIT  4
`define EFR_CFG_PAT_BIT   3
`define EFR_LIVE_RST      5'h0D
`define EFR_B_EXCRC       5
`define EFR_B_SMFP        7
`define EFR_B_CSMFP       6
`define EFR_B_SMFER       5
`define EFR_B_CMFP        4
`define EFR_B_CMFER       3
`define EFR_B_CRCE        2
`define EFR_B_FER         1
`define EFR_B_COFA        0
`define EFR_SMFAS_EXP     4'h0
`define EFR_CMFAS_EXP     6'h0B
`define EFR_FAS_EXP       7'h1B
`define EFR_NFAS_EXP      1'h1
`define EFR_EXCRC_LIMIT   10'h393
`define EFR_CNT_MAX       10'h3FF
`define EFR_WINDOW_NS     1000000000
`define EFR_CLK_NS        5
`endif

/* File: include/efr_pkg.sv */
package efr_pkg;
    typedef enum logic [1:0] {
        EFR_IDLE = 2'b01,
        EFR_ACK  = 2'b10
    } efr_bus_t;

    typedef struct packed {
        efr_bus_t         bus;
        logic             waitrequest;
        logic [31:0]      rdata;
        logic             irq;
        logic [7:0][4:0]  live;
        logic [7:0][7:0]  sync_en;
        logic [7:0][7:0]  evt_en;
        logic [7:0][7:0]  sync_flg;
        logic [7:0][7:0]  evt_flg;
        logic [7:0][7:0]  cfg;
        logic [7:0][9:0]  crc_cnt;
        logic [7:0][7:0]  pos;
        logic [7:0]       pos_ok;
        logic [27:0]      win;
    } efr_state_t;
endpackage

/* File: verif/efr_line_model.sv */
`timescale 1ns/1ps
`default_nettype none

module efr_line_model (
    input  wire logic       sys_clk,
    output logic [7:0]      interworking_state,
    output logic [7:0]      sig_mf_out_of_sync,
    output logic [7:0]      crc_mf_out_of_sync,
    output logic [7:0]      offline_frame_out_of_sync,
    output logic [7:0]      basic_frame_out_of_sync,
    output logic [7:0]      sig_mf_start,
    output logic [7:0]      crc_submf_start,
    output logic [7:0]      crc_mf_start,
    output logic [7:0]      sig_mfas_strobe,
    output logic [7:0][3:0] sig_mfas_word,
    output logic [7:0]      crc_mfas_strobe,
    output logic [7:0][5:0] crc_mfas_bits,
    output logic [7:0]      crc4_strobe,
    output logic [7:0][3:0] crc4_calc,
    output logic [7:0][3:0] crc4_rx,
    output logic [7:0]      fas_strobe,
    output logic [7:0][6:0] fas_word,
    output logic [7:0]      nfas_strobe,
    output logic [7:0]      nfas_bit,
    output logic [7:0]      align_found,
    output logic [7:0][7:0] align_pos
);
    // line comes up unframed: basic, crc and signaling searches still running
    initial begin
        {interworking_state, offline_frame_out_of_sync} = '0;
        {sig_mf_out_of_sync, crc_mf_out_of_sync, basic_frame_out_of_sync} = '1;
        {sig_mf_start, crc_submf_start, crc_mf_start, sig_mfas_strobe, crc_mfas_strobe} = '0;
        {crc4_strobe, fas_strobe, nfas_strobe, align_found, sig_mfas_word, align_pos} = '0;
        crc_mfas_bits = {8{6'h0B}};
        crc4_calc = {8{4'h5}};
        crc4_rx = {8{4'h5}};
        fas_word = {8{7'h1B}};
        nfas_bit = '1;
    end

    // only channel 0 carries traffic, the rest sit in their search state
    task automatic lv(input logic [4:0] v);
        @(posedge sys_clk);
        {interworking_state[0], sig_mf_out_of_sync[0], crc_mf_out_of_sync[0],
         offline_frame_out_of_sync[0], basic_frame_out_of_sync[0]} <= v;
    endtask

    // k follows the event flag bit order, 8 is an nfas bit; held n cycles
    task automatic ev(input int k, input logic bad, input int n);
        @(posedge sys_clk);
        case (k)
            0: begin align_found[0] <= 1'b1; align_pos[0] <= bad ? 8'h05 : 8'h03; end
            1: begin fas_strobe[0] <= 1'b1; fas_word[0] <= bad ? 7'h1A : 7'h1B; end
            2: begin crc4_strobe[0] <= 1'b1; crc4_rx[0] <= bad ? 4'h6 : 4'h5; end
            3: begin crc_mfas_strobe[0] <= 1'b1; crc_mfas_bits[0] <= bad ? 6'h0A : 6'h0B; end
            4: crc_mf_start[0] <= 1'b1;
            5: begin sig_mfas_strobe[0] <= 1'b1; sig_mfas_word[0] <= bad ? 4'h8 : 4'h0; end
            6: crc_submf_start[0] <= 1'b1;
            7: sig_mf_start[0] <= 1'b1;
            default: begin nfas_strobe[0] <= 1'b1; nfas_bit[0] <= !bad; end
        endcase
        repeat (n) @(posedge sys_clk);
        {sig_mf_start, crc_submf_start, crc_mf_start, sig_mfas_strobe, crc_mfas_strobe} <= '0;
        {crc4_strobe, fas_strobe, nfas_strobe, align_found} <= '0;
    endtask
endmodule // efr_line_model

`default_nettype wire

/* File: verif/efr_sync_event_reporting_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module efr_sync_event_reporting_bench
    import efr_pkg::*;
;
    logic sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq;
    logic [10:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic [7:0] interworking_state, sig_mf_out_of_sync, crc_mf_out_of_sync, offline_frame_out_of_sync;
    logic [7:0] basic_frame_out_of_sync, sig_mf_start, crc_submf_start, crc_mf_start, sig_mfas_strobe;
    logic [7:0] crc_mfas_strobe, crc4_strobe, fas_strobe, nfas_strobe, nfas_bit, align_found;
    logic [7:0][3:0] sig_mfas_word, crc4_calc, crc4_rx;
    logic [7:0][5:0] crc_mfas_bits;
    logic [7:0][6:0] fas_word;
    logic [7:0][7:0] align_pos;
    logic [7:0] q;
    int mismatches = 0;
    int samples_checked = 0;

    always #2.5 sys_clk = ~sys_clk;

    // short excess window keeps the run brief
    efr_sync_event_reporting #(.WINDOW_CYCLES(2000)) i_efr_sync_event_reporting (.sys_clk, .rst_n,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
        .interworking_state, .sig_mf_out_of_sync, .crc_mf_out_of_sync, .offline_frame_out_of_sync,
        .basic_frame_out_of_sync, .sig_mf_start, .crc_submf_start, .crc_mf_start, .sig_mfas_strobe,
        .sig_mfas_word, .crc_mfas_strobe, .crc_mfas_bits, .crc4_strobe, .crc4_calc, .crc4_rx,
        .fas_strobe, .fas_word, .nfas_strobe, .nfas_bit, .align_found, .align_pos);
    efr_line_model i_efr_line_model (.sys_clk, .interworking_state, .sig_mf_out_of_sync,
        .crc_mf_out_of_sync, .offline_frame_out_of_sync, .basic_frame_out_of_sync, .sig_mf_start,
        .crc_submf_start, .crc_mf_start, .sig_mfas_strobe, .sig_mfas_word, .crc_mfas_strobe,
        .crc_mfas_bits, .crc4_strobe, .crc4_calc, .crc4_rx, .fas_strobe, .fas_word, .nfas_strobe,
        .nfas_bit, .align_found, .align_pos);

    task automatic bus(input logic wr, input logic [10:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40) begin
            $display("FAIL bus %h exp ack got none", a);
            mismatches++;
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rc(input logic [10:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        samples_checked++;
        if (q !== e) begin
            $display("FAIL reg %h exp %h got %h", a, e, q);
            mismatches++;
        end
    endtask

    // irq trails the flags by a cycle, so let it settle first
    task automatic ic(input logic e);
        repeat (3) @(posedge sys_clk);
        samples_checked++;
        if (irq !== e) begin
            $display("FAIL irq exp %b got %b", e, irq);
            mismatches++;
        end
    endtask

    task automatic t_reset;
        rc(11'h04F, 8'h0D);
        rc(11'h050, 8'h00);
        rc(11'h052, 8'h00);
        rc(11'h053, 8'h00);
        ic(1'b0);
        $display("t_reset done");
    endtask

    task automatic t_live;
        logic [4:0] v;
        v = 5'h0D;
        for (int i = 0; i < 5; i++) begin
            v[i] = ~v[i];
            i_efr_line_model.lv(v);
            rc(11'h04F, {3'h0, v});
            rc(11'h052, 8'h01 << i);
            wr(11'h050, 8'h01 << i);
            ic(1'b1);
            wr(11'h050, 8'h00);
            ic(1'b0);
            wr(11'h052, 8'h3F ^ (8'h01 << i));
            rc(11'h052, 8'h01 << i);
            wr(11'h052, 8'h01 << i);
            rc(11'h052, 8'h00);
        end
        $display("t_live done");
    endtask

    task automatic t_events;
        wr(11'h04E, 8'h00);
        wr(11'h051, 8'hFF);
        i_efr_line_model.ev(0, 1'b0, 1);
        for (int k = 0; k < 8; k++) begin
            i_efr_line_model.ev(k, 1'b0, 1);
            rc(11'h053, (k == 4 || k > 5) ? 8'h01 << k : 8'h00);
            i_efr_line_model.ev(k, 1'b1, 1);
            rc(11'h053, 8'h01 << k);
            ic(1'b1);
            wr(11'h053, 8'h01 << k);
            ic(1'b0);
        end
        for (int c = 0; c < 4; c++) begin
            wr(11'h04E, 8'(c << 3));
            i_efr_line_model.ev(8, 1'b1, 1);
            rc(11'h053, c[1] ? 8'h02 : 8'h00);
            i_efr_line_model.ev(1, 1'b1, 1);
            rc(11'h053, 8'h02);
            wr(11'h053, 8'h02);
        end
        $display("t_events done");
    endtask

    task automatic t_suspend;
        i_efr_line_model.lv(5'h1F);
        wr(11'h052, 8'h3F);
        for (int k = 1; k < 8; k++) i_efr_line_model.ev(k, 1'b1, 1);
        i_efr_line_model.ev(2, 1'b1, 1830);
        rc(11'h053, 8'h00);
        rc(11'h052, 8'h00);
        i_efr_line_model.lv(5'h12);
        wr(11'h052, 8'h3F);
        i_efr_line_model.ev(2, 1'b1, 914);
        rc(11'h052, 8'h00);
        // any window edge leaves one side of this burst at 915 or more
        i_efr_line_model.ev(2, 1'b1, 1830);
        rc(11'h052, 8'h20);
        $display("t_suspend done");
    endtask

    task automatic t_chan;
        wr(11'h751, 8'hA5);
        rc(11'h751, 8'hA5);
        rc(11'h651, 8'h00);
        rc(11'h74F, 8'h0D);
        wr(11'h050, 8'hFF);
        rc(11'h050, 8'h1F);
        wr(11'h0FF, 8'hFF);
        rc(11'h0FF, 8'h00);
        $display("t_chan done");
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset;
        t_live;
        t_events;
        t_suspend;
        t_chan;
        end_sim;
    end

    // the tests need well under 20000 cycles
    initial begin
        #100000;
        mismatches++;
        end_sim;
    end
endmodule // efr_sync_event_reporting_bench

`default_nettype wire
